// ==== logic/dmc_pkg.sv ====
// Shared constants, types and field layout for the DDR4 mode configuration block
`default_nettype none
package dmc_pkg;

    // Link command codes as decoded from the command pins
    typedef enum logic [2:0] {
        CMD_NOP  = 3'h0,
        CMD_MRS  = 3'h1,
        CMD_ACT  = 3'h2,
        CMD_RD   = 3'h3,
        CMD_WR   = 3'h4,
        CMD_SYNC = 3'h5
    } dmc_cmd_t;

    typedef enum logic [1:0] {
        T_PARK = 2'h0,
        T_NOM  = 2'h1,
        T_WR   = 2'h2
    } dmc_term_t;

    typedef struct packed {
        logic        csN;
        dmc_cmd_t    cmd;
        logic        grpSel;
        logic [1:0]  bank;
        logic [13:0] addr;
        logic        die_termination_input;
        logic        pdaSelN;
    } dmc_link_t;

    typedef struct packed {
        logic [1:0] drvImp;
        logic       outOff;
        dmc_term_t  termSrc;
        logic [2:0] termVal;
        logic       strobeTermEn;
        logic       dmEn;
        logic       wrDbiEn;
        logic       rdDbiEn;
        logic [3:0] burstUi;
        logic       wrPre2;
        logic       rdPre2;
        logic       quarterRate;
    } dmc_cfg_t;

    // Mode register indices on {group_select_bit, bank}
    localparam logic [2:0] MRI_0 = 3'h0;
    localparam logic [2:0] MRI_1 = 3'h1;
    localparam logic [2:0] MRI_2 = 3'h2;
    localparam logic [2:0] MRI_3 = 3'h3;
    localparam logic [2:0] MRI_RSVD = 3'h7;
    localparam logic [13:0] MR_RST = 14'h0000;
    localparam logic [13:0] MR1_RST = 14'h0001;

    // Field positions
    localparam int MR0_CL = 4;
    localparam int MR1_DLL = 0;
    localparam int MR1_DRV = 1;
    localparam int MR1_AL = 3;
    localparam int MR1_WLEV = 7;
    localparam int MR1_NOM = 8;
    localparam int MR1_TERMINATION_STROBE = 11;
    localparam int MR1_QOFF = 12;
    localparam int MR2_CWL = 3;
    localparam int MR2_RTTWR = 9;
    localparam int MR2_CRC = 12;
    localparam int MR3_GEAR = 3;
    localparam int MR3_PDA = 4;
    localparam int MR3_TEMP = 5;
    localparam int MR3_WCL = 9;
    localparam int MR4_RPRE = 11;
    localparam int MR4_WPRE = 12;
    localparam int MR5_PARK = 6;
    localparam int MR5_DM = 10;
    localparam int MR5_WDBI = 11;
    localparam int MR5_RDBI = 12;

    // Latency arithmetic, in link clocks
    localparam logic [5:0] CL_BASE = 6'h09;
    localparam logic [5:0] CWL_BASE = 6'h09;
    localparam logic [5:0] AL_SUB1 = 6'h01;
    localparam logic [5:0] AL_SUB2 = 6'h02;
    localparam logic [1:0] AL_M1 = 2'h1;
    localparam logic [1:0] AL_M2 = 2'h2;
    localparam logic [2:0] CWL_LOW = 3'h0;
    localparam logic [3:0] BL_NORM = 4'h8;
    localparam logic [3:0] BL_CRC = 4'hA;

    // Register map, byte addresses
    localparam logic [7:0] REG_STATUS = 8'h00;
    localparam logic [7:0] REG_MRSEL = 8'h04;
    localparam logic [7:0] REG_MRDATA = 8'h08;
    localparam logic [7:0] REG_LAT = 8'h0C;
    localparam logic [7:0] REG_TEMP = 8'h10;
    localparam logic [7:0] REG_CTRL = 8'h14;
    localparam int CTRL_ORG = 0;
    localparam int CTRL_CLR = 1;

    // Temperature status freshness
    localparam int TEMP_MS = 32;
    localparam int SYS_HZ = 10_000_000;
    localparam int TEMP_CYC_DEF = TEMP_MS * (SYS_HZ / 1000);

endpackage
`default_nettype wire

// ==== logic/dmc_sync.sv ====
// Two-stage synchroniser for pins arriving from the link side
`timescale 1ns/10ps
`default_nettype none
module dmc_sync #(
    parameter int W = 1
) (
    input  wire logic         sys_clk,
    input  wire logic         arst_n,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    if (W < 1) begin : g_chk
        $error("dmc_sync width must be positive");
    end

    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= '0;
            dout   <= '0;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== logic/dmc_delay.sv ====
// Link-clock delay line with two programmable taps
`timescale 1ns/10ps
`default_nettype none
module dmc_delay #(
    parameter int DEPTH = 64,
    parameter int TW    = $clog2(DEPTH)
) (
    input  wire logic          sys_clk,
    input  wire logic          arst_n,
    input  wire logic          tick,
    input  wire logic          inPulse,
    input  wire logic [TW-1:0] tapA,
    input  wire logic [TW-1:0] tapB,
    output logic               outA,
    output logic               outB
);
    logic [DEPTH-1:0] line_q;

    if (DEPTH < 40) begin : g_chk
        $error("dmc_delay depth too small for the longest latency");
    end

    // Tap n fires n link clocks after the command's own link edge
    assign outA = tick & ((tapA == '0) ? inPulse : line_q[tapA - 1'b1]);
    assign outB = tick & ((tapB == '0) ? inPulse : line_q[tapB - 1'b1]);

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            line_q <= '0;
        end else if (tick) begin
            line_q <= {line_q[DEPTH-2:0], inPulse};
        end
    end
endmodule
`default_nettype wire

// ==== logic/dmc_top.sv ====
// Mode register store, link decode, termination and latency control
// Function
// - Driver impedance comes from mode register one bits 2:1.
// - Write termination applies during writes with die termination input high, even with nominal disabled.
// - Park termination applies whenever die termination input is low.
// - Reads and writes accepted with no activate check, issued after additive latency.
// - Read data delay is additive plus CAS read delay.
// - Write data delay is additive plus CAS write delay from bits 5:3, plus write command delay with CRC and masking on.
// - Output disable bit disconnects all data and strobe outputs.
// - Extra strobe pair gets same termination as data strobe pair.
// - Termination strobe enabled excludes byte masking and bus inversion.
// - Byte masking and write inversion exclusive; read inversion independent.
// - Mode commands to reserved index seven are ignored and counted as dropped.
// - Dynamic termination from bits 11:9; write leveling offers nominal or park only.
// - Write CRC stretches write bursts from eight to ten intervals.
// - Temperature status refreshed often enough to be at most 32 ms old.
// - Per-device mask gates mode commands within a shared rank.
// - Start in 1N; 2N needs mode command then sync pulse.
// - Write preamble one or two clocks; two needs CAS write above lowest.
// - Read preamble one or two clocks from mode register four.
`timescale 1ns/10ps
`default_nettype none
module dmc_top #(
    parameter int TEMP_CYC  = dmc_pkg::TEMP_CYC_DEF,
    parameter int LAT_DEPTH = 64
) (
    input  wire logic              sys_clk,
    input  wire logic              arst_n,
    input  wire logic [7:0]        avs_address,
    input  wire logic              avs_read,
    input  wire logic              avs_write,
    input  wire logic [31:0]       avs_writedata,
    output logic      [31:0]       avs_readdata,
    output logic                   avs_waitrequest,
    input  wire logic              linkClk,
    input  wire dmc_pkg::dmc_link_t linkPins,
    input  wire logic [1:0]        tempCode,
    output dmc_pkg::dmc_cfg_t      cfg,
    output logic                   rdIssue,
    output logic                   wrIssue,
    output logic                   rdData,
    output logic                   wrData
);
    import dmc_pkg::*;

    localparam int LW = $bits(dmc_link_t);
    localparam int TMRW = $clog2(TEMP_CYC + 1);

    if (TEMP_CYC < 2 || LAT_DEPTH < 40) begin : g_chk
        $error("dmc_top parameters out of range");
    end

    logic [13:0]     modeReg_q [0:7];
    logic            ack_q;
    logic            clkPrev_q;
    logic [2:0]      mrSel_q;
    logic            orgX8_q;
    logic [7:0]      ignCnt_q;
    logic            gearPend_q;
    logic            quarter_q;
    logic [2:0]      wrLeft_q;
    logic [TMRW-1:0] tmr_q;
    logic [1:0]      mprTemp_q;
    logic [31:0]     rdMux;
    logic [LW:0]     pinSync;
    dmc_link_t       lnk;
    dmc_cfg_t        cfg_d;
    logic            rdIssueP;
    logic            wrIssueP;
    logic            rdDataP;
    logic            wrDataP;

    // Avalon slave: one wait state, then the access completes
    wire logic busReq = avs_read | avs_write;
    wire logic busWr = avs_write & ack_q;
    assign avs_waitrequest = busReq & ~ack_q;

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_q        <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            ack_q <= busReq & ~ack_q;
            if (avs_read & ~ack_q) begin
                avs_readdata <= rdMux;
            end
        end
    end

    // Link pins, including the link clock, are oversampled by sys_clk
    dmc_sync #(
        .W (LW + 1)
    ) uSync (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .din     ({linkClk, linkPins}),
        .dout    (pinSync)
    );

    assign lnk = dmc_link_t'(pinSync[LW-1:0]);
    wire logic tick = pinSync[LW] & ~clkPrev_q;
    wire logic cmdValid = tick & ~lnk.csN;
    wire logic [2:0] mrIdx = {lnk.grpSel, lnk.bank};
    wire logic isMrs = cmdValid & (lnk.cmd == CMD_MRS);
    wire logic mrsRsvd = isMrs & (mrIdx == MRI_RSVD);
    wire logic pdaOn = modeReg_q[MRI_3][MR3_PDA];
    wire logic mrsSel = ~pdaOn | ~lnk.pdaSelN;
    wire logic mrsTake = isMrs & ~mrsRsvd & mrsSel;
    wire logic mrsDrop = isMrs & ~mrsTake;
    wire logic rdCmd = cmdValid & (lnk.cmd == CMD_RD);
    wire logic wrCmd = cmdValid & (lnk.cmd == CMD_WR);
    wire logic syncCmd = cmdValid & (lnk.cmd == CMD_SYNC);
    wire logic ignClr = busWr & (avs_address == REG_CTRL) & avs_writedata[CTRL_CLR];

    // Unused address bits are stored as given; the controller keeps them zero
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 8; i++) begin
                modeReg_q[i] <= MR_RST;
            end
            modeReg_q[MRI_1] <= MR1_RST;
        end else if (mrsTake) begin
            modeReg_q[mrIdx] <= lnk.addr;
        end
    end

    // Field extraction
    wire logic [13:0] mr0 = modeReg_q[0];
    wire logic [13:0] mr1 = modeReg_q[1];
    wire logic [13:0] mr2 = modeReg_q[2];
    wire logic [13:0] mr3 = modeReg_q[3];
    wire logic [13:0] mr4 = modeReg_q[4];
    wire logic [13:0] mr5 = modeReg_q[5];
    wire logic [1:0] drvImp = mr1[MR1_DRV +: 2];
    wire logic dllOff = ~mr1[MR1_DLL];
    wire logic wlev = mr1[MR1_WLEV];
    wire logic [2:0] rttNom = mr1[MR1_NOM +: 3];
    wire logic [2:0] rttWr = mr2[MR2_RTTWR +: 3];
    wire logic [2:0] rttPark = mr5[MR5_PARK +: 3];
    wire logic [1:0] alCode = mr1[MR1_AL +: 2];
    wire logic [2:0] clCode = mr0[MR0_CL +: 3];
    wire logic [2:0] cwlCode = mr2[MR2_CWL +: 3];
    wire logic [1:0] wclCode = mr3[MR3_WCL +: 2];
    wire logic crcEn = mr2[MR2_CRC];
    wire logic tempEn = mr3[MR3_TEMP];

    // Latencies in link clocks, whole clocks only
    wire logic [5:0] casRd = CL_BASE + {3'h0, clCode};
    wire logic [5:0] casWr = CWL_BASE + {3'h0, cwlCode};
    wire logic [5:0] addLat = (alCode == AL_M1) ? casRd - AL_SUB1 :
                              (alCode == AL_M2) ? casRd - AL_SUB2 : 6'h00;
    wire logic [5:0] totRd = addLat + casRd;
    // Extra write command delay only counts when CRC and masking are both on
    wire logic [5:0] wclAdd = (crcEn & cfg_d.dmEn) ? {4'h0, wclCode} : 6'h00;
    wire logic [5:0] totWr = addLat + casWr + wclAdd;

    // Shared pin functions; masking wins if software asks for both
    wire logic tdqsEn = mr1[MR1_TERMINATION_STROBE] & orgX8_q;
    assign cfg_d.strobeTermEn = tdqsEn;
    assign cfg_d.dmEn = ~tdqsEn & mr5[MR5_DM];
    assign cfg_d.wrDbiEn = ~tdqsEn & ~cfg_d.dmEn & mr5[MR5_WDBI];
    assign cfg_d.rdDbiEn = ~tdqsEn & mr5[MR5_RDBI];
    assign cfg_d.burstUi = crcEn ? BL_CRC : BL_NORM;
    assign cfg_d.drvImp = drvImp;
    assign cfg_d.outOff = mr1[MR1_QOFF];
    assign cfg_d.wrPre2 = mr4[MR4_WPRE];
    assign cfg_d.rdPre2 = mr4[MR4_RPRE];
    assign cfg_d.quarterRate = quarter_q;
    wire logic preErr = cfg_d.wrPre2 & (cwlCode == CWL_LOW);

    // Termination: park when the input is low, write value inside a write burst
    // Dynamic termination in DLL-off relies on the controller zeroing rttWr
    wire logic wrWin = wrDataP | (wrLeft_q != 3'h0);
    wire logic wrTermOn = wrWin & (rttWr != 3'h0) & ~wlev;
    assign cfg_d.termSrc = ~lnk.die_termination_input ? T_PARK : wrTermOn ? T_WR : T_NOM;
    assign cfg_d.termVal = ~lnk.die_termination_input ? rttPark : wrTermOn ? rttWr : rttNom;

    // Command delay lines, stepped on each link rising edge
    dmc_delay #(
        .DEPTH (LAT_DEPTH)
    ) uRdLine (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .tick    (tick),
        .inPulse (rdCmd),
        .tapA    (addLat),
        .tapB    (totRd),
        .outA    (rdIssueP),
        .outB    (rdDataP)
    );

    dmc_delay #(
        .DEPTH (LAT_DEPTH)
    ) uWrLine (
        .sys_clk (sys_clk),
        .arst_n  (arst_n),
        .tick    (tick),
        .inPulse (wrCmd),
        .tapA    (addLat),
        .tapB    (totWr),
        .outA    (wrIssueP),
        .outB    (wrDataP)
    );

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            clkPrev_q <= 1'b0;
            cfg       <= '0;
            rdIssue   <= 1'b0;
            wrIssue   <= 1'b0;
            rdData    <= 1'b0;
            wrData    <= 1'b0;
        end else begin
            clkPrev_q <= pinSync[LW];
            cfg       <= cfg_d;
            rdIssue   <= rdIssueP;
            wrIssue   <= wrIssueP;
            rdData    <= rdDataP;
            wrData    <= wrDataP;
        end
    end

    // Write window lasts half the burst intervals in link clocks
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wrLeft_q <= 3'h0;
        end else if (wrDataP) begin
            wrLeft_q <= cfg_d.burstUi[3:1];
        end else if (tick && wrLeft_q != 3'h0) begin
            wrLeft_q <= wrLeft_q - 3'h1;
        end
    end

    // Gear-down: arm on the mode command, switch on the following sync pulse
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            gearPend_q <= 1'b0;
            quarter_q  <= 1'b0;
        end else if (mrsTake && mrIdx == MRI_3) begin
            gearPend_q <= lnk.addr[MR3_GEAR] & ~quarter_q;
            quarter_q  <= quarter_q & lnk.addr[MR3_GEAR];
        end else if (syncCmd && gearPend_q) begin
            gearPend_q <= 1'b0;
            quarter_q  <= 1'b1;
        end
    end

    // Temperature status is sampled on enable and then every TEMP_CYC cycles
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tmr_q     <= '0;
            mprTemp_q <= 2'h0;
        end else if (!tempEn) begin
            tmr_q <= '0;
        end else begin
            tmr_q <= (tmr_q == TMRW'(TEMP_CYC - 1)) ? '0 : tmr_q + 1'b1;
            if (tmr_q == '0) begin
                mprTemp_q <= tempCode;
            end
        end
    end

    // Dropped mode commands are counted; a drop with a same-cycle clear leaves a count of one
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ignCnt_q <= 8'h00;
        end else if (mrsDrop) begin
            ignCnt_q <= ignClr ? 8'h01 : (ignCnt_q == 8'hFF) ? ignCnt_q : ignCnt_q + 8'h01;
        end else if (ignClr) begin
            ignCnt_q <= 8'h00;
        end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            mrSel_q <= 3'h0;
            orgX8_q <= 1'b0;
        end else if (busWr && avs_address == REG_MRSEL) begin
            mrSel_q <= avs_writedata[2:0];
        end else if (busWr && avs_address == REG_CTRL) begin
            orgX8_q <= avs_writedata[CTRL_ORG];
        end
    end

    // Unmapped addresses read as zero and ignore writes
    assign rdMux =
        (avs_address == REG_STATUS) ? {16'h0000, ignCnt_q, 3'h0, preErr, quarter_q,
                                       dllOff, cfg.outOff, cfg.strobeTermEn} :
        (avs_address == REG_MRSEL)  ? {29'h0000_0000, mrSel_q} :
        (avs_address == REG_MRDATA) ? {18'h0_0000, modeReg_q[mrSel_q]} :
        (avs_address == REG_LAT)    ? {12'h000, cfg.burstUi, 2'h0, totWr, 2'h0, totRd} :
        (avs_address == REG_TEMP)   ? {29'h0000_0000, tempEn, mprTemp_q} :
        (avs_address == REG_CTRL)   ? {31'h0000_0000, orgX8_q} : 32'h0000_0000;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);

    sequence s_mr1_write;
        mrsTake && mrIdx == MRI_1;
    endsequence

    sequence s_sync_armed;
        syncCmd && gearPend_q;
    endsequence

    a_rsvd_ignored: assert property (mrsRsvd |=> $stable(mr1) && $stable(mr3))
        else $error("reserved mode command changed a register");
    a_drv_select: assert property (s_mr1_write ##1 1 |=>
        cfg.drvImp == $past(lnk.addr[MR1_DRV +: 2], 2))
        else $error("driver impedance not taken from mode register one");
    a_out_disable: assert property (s_mr1_write ##1 1 |=>
        cfg.outOff == $past(lnk.addr[MR1_QOFF], 2))
        else $error("output disable not following mode register one");
    a_park_low: assert property (!lnk.die_termination_input |=> cfg.termSrc == T_PARK
        && cfg.termVal == $past(rttPark))
        else $error("park termination missing with input low");
    a_wr_term: assert property (lnk.die_termination_input && wrTermOn |=> cfg.termSrc == T_WR)
        else $error("write termination missing during write");
    a_wlev_nom: assert property (lnk.die_termination_input && wlev |=> cfg.termSrc == T_NOM)
        else $error("non-nominal termination in write leveling");
    a_strobe_excl: assert property (cfg.strobeTermEn |->
        !cfg.dmEn && !cfg.wrDbiEn && !cfg.rdDbiEn)
        else $error("shared pin function active with termination strobe");
    a_mask_dbi: assert property (!(cfg.dmEn && cfg.wrDbiEn))
        else $error("byte masking and write inversion both on");
    a_crc_burst: assert property (crcEn ##1 crcEn |-> cfg.burstUi == BL_CRC)
        else $error("CRC burst length not ten");
    a_gear_sync: assert property (s_sync_armed |=> quarter_q)
        else $error("sync pulse did not enter quarter rate");
    a_gear_cause: assert property ($rose(quarter_q) |-> $past(syncCmd))
        else $error("quarter rate entered without sync pulse");
    a_temp_fresh: assert property (tempEn |-> tmr_q < TMRW'(TEMP_CYC))
        else $error("temperature status older than limit");
    a_rd_issue: assert property (rdCmd && addLat == 6'h00 |=> rdIssue)
        else $error("read not issued at zero additive latency");
    a_pda_skip: assert property (isMrs && pdaOn && lnk.pdaSelN |=> $stable(mr1))
        else $error("deselected device took a mode command");
endmodule
`default_nettype wire

// ==== bench/dmc_ctl_model.sv ====
// Controller model: free link clock and command pins
`timescale 1ns/10ps
`default_nettype none
module dmc_ctl_model (
    input  wire logic              sys_clk,
    output logic                   linkClk,
    output var dmc_pkg::dmc_link_t linkPins
);
    import dmc_pkg::*;
    initial begin
        linkClk = 1'b0;
        linkPins = '1;
        #137;
        forever #400 linkClk = ~linkClk;
    end
    // Held from fall to fall around the sampling rise; stale pins scrambled after
    task automatic send(input dmc_cmd_t c, input logic [2:0] i,
                        input logic [13:0] v, input logic die_termination_input, input logic pdaN);
        @(negedge linkClk);
        @(posedge sys_clk);
        linkPins <= '{1'b0, c, i[2], i[1:0], v, die_termination_input, pdaN};
        @(negedge linkClk);
        @(posedge sys_clk);
        linkPins <= '{1'b1, CMD_NOP, ~i[2], ~i[1:0], ~v, die_termination_input, 1'b1};
    endtask
endmodule
`default_nettype wire

// ==== bench/dmc_top_tb_top.sv ====
// Self-checking bench for the mode configuration block
`timescale 1ns/10ps
`default_nettype none
module dmc_top_tb_top;
    import dmc_pkg::*;
    logic        sys_clk, arst_n, avs_read, avs_write, avs_waitrequest;
    logic        linkClk, rdIssue, wrIssue, rdData, wrData;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [1:0]  tempCode;
    dmc_link_t   linkPins;
    dmc_cfg_t    cfg;
    int          nErrors = 0;
    int          numChecks = 0;
    dmc_top #(.TEMP_CYC(50), .LAT_DEPTH(64)) u_dut (.sys_clk(sys_clk), .arst_n(arst_n),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .linkClk(linkClk), .linkPins(linkPins),
        .tempCode(tempCode), .cfg(cfg), .rdIssue(rdIssue), .wrIssue(wrIssue),
        .rdData(rdData), .wrData(wrData));
    dmc_ctl_model u_ctl (.sys_clk(sys_clk), .linkClk(linkClk), .linkPins(linkPins));
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic finish_test;
        if (nErrors == 0 && numChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // No cap on the wait: only the watchdog ends a hung access
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic mrs(input logic [2:0] i, input logic [13:0] v);
        u_ctl.send(CMD_MRS, i, v, 1'b0, 1'b0);
        repeat (8) @(posedge sys_clk);
    endtask
    // Issue-to-data spacing in system cycles; one link clock is eight
    task automatic lat(input dmc_cmd_t c, input int exp, input logic die_termination_input);
        int n;
        n = 0;
        u_ctl.send(c, 3'h0, 14'h0000, die_termination_input, 1'b0);
        do @(posedge sys_clk); while ((c == CMD_RD ? rdIssue : wrIssue) !== 1'b1);
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while ((c == CMD_RD ? rdData : wrData) !== 1'b1 && n < 900);
        chk(n, exp);
    endtask
    task automatic t_basic;
        // Idle pins hold the termination input high, so nominal is selected
        chk(cfg, {2'h0, 1'b0, T_NOM, 3'h0, 4'h0, BL_NORM, 3'h0});
        bus(1'b1, REG_MRSEL, 32'h0000_0001);
        bus(1'b0, REG_MRDATA, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        bus(1'b0, 8'hFC, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        mrs(MRI_1, 14'h1005);
        chk({cfg.drvImp, cfg.outOff}, 3'b101);
        mrs(MRI_1, 14'h0003);
        chk({cfg.drvImp, cfg.outOff}, 3'b010);
    endtask
    task automatic t_ignore;
        mrs(MRI_RSVD, 14'h1004);
        chk({cfg.drvImp, cfg.outOff}, 3'b010);
        mrs(MRI_3, 14'h0010);
        u_ctl.send(CMD_MRS, MRI_1, 14'h0005, 1'b0, 1'b1);
        repeat (8) @(posedge sys_clk);
        chk(cfg.drvImp, 2'h1);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        chk(rd[15:8], 8'h02);
        mrs(MRI_3, 14'h0000);
        bus(1'b1, REG_CTRL, 32'h0000_0002);
    endtask
    task automatic t_latency;
        mrs(MRI_0, 14'h0030);
        mrs(MRI_1, 14'h0009);
        mrs(MRI_2, 14'h0010);
        bus(1'b0, REG_LAT, 32'h0000_0000);
        chk(rd, 32'h0008_1617);
        lat(CMD_RD, 96, 1'b0);
        lat(CMD_WR, 88, 1'b0);
        mrs(MRI_2, 14'h1010);
        chk(cfg.burstUi, 4'hA);
    endtask
    task automatic t_term;
        mrs(3'h5, 14'h1D40);
        chk({cfg.termSrc, cfg.termVal}, {T_PARK, 3'h5});
        chk({cfg.dmEn, cfg.wrDbiEn, cfg.rdDbiEn}, 3'b101);
        bus(1'b1, REG_CTRL, 32'h0000_0001);
        mrs(MRI_1, 14'h0809);
        chk({cfg.strobeTermEn, cfg.dmEn, cfg.wrDbiEn, cfg.rdDbiEn}, 4'h8);
        mrs(3'h4, 14'h1800);
        chk({cfg.wrPre2, cfg.rdPre2}, 2'b11);
        mrs(MRI_2, 14'h1410);
        lat(CMD_WR, 88, 1'b1);
        chk({cfg.termSrc, cfg.termVal}, {T_WR, 3'h2});
        repeat (60) @(posedge sys_clk);
        chk({cfg.termSrc, cfg.termVal}, {T_NOM, 3'h0});
        // Write termination is zeroed before the DLL is switched off
        mrs(MRI_2, 14'h1010);
        mrs(MRI_1, 14'h0808);
        bus(1'b0, REG_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        mrs(MRI_3, 14'h0200);
        mrs(MRI_1, 14'h0001);
        u_ctl.send(CMD_RD, 3'h0, 14'h0000, 1'b0, 1'b0);
        bus(1'b0, REG_LAT, 32'h0000_0000);
        chk(rd, 32'h000A_0C0C);
    endtask
    task automatic t_gear_temp;
        chk(cfg.quarterRate, 1'b0);
        tempCode <= 2'h1;
        mrs(MRI_3, 14'h0228);
        chk(cfg.quarterRate, 1'b0);
        bus(1'b0, REG_TEMP, 32'h0000_0000);
        chk(rd, 32'h0000_0005);
        u_ctl.send(CMD_SYNC, 3'h0, 14'h0000, 1'b0, 1'b0);
        tempCode <= 2'h2;
        repeat (60) @(posedge sys_clk);
        chk(cfg.quarterRate, 1'b1);
        bus(1'b0, REG_TEMP, 32'h0000_0000);
        chk(rd, 32'h0000_0006);
    endtask
    initial begin
        repeat (20000) @(posedge sys_clk);
        nErrors++;
        finish_test();
    end
    initial begin
        arst_n = 1'b0;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        tempCode = 2'h0;
        repeat (16) @(posedge sys_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        t_basic();
        t_ignore();
        t_latency();
        t_term();
        t_gear_temp();
        finish_test();
    end
endmodule
`default_nettype wire
